// ===== hw/ism_pkg.sv
package ism_pkg;
  // Character that announces readiness for the next operation
  localparam logic [7:0] READY_CHAR = 8'h21;
  // Monitor command selection codes
  localparam logic [3:0] SEL_ALARM_CLEAR  = 4'h0;
  localparam logic [3:0] SEL_IN_OPERATION = 4'h1;
  localparam logic [3:0] SEL_JOG_DIR      = 4'h2;
  localparam logic [3:0] SEL_DRIVE_READY  = 4'h3;
  localparam logic [3:0] SEL_EMERG_STOP   = 4'h4;
  localparam logic [3:0] SEL_HOME_DEFINED = 4'h5;
  localparam logic [3:0] SEL_HOLD         = 4'h6;
  localparam logic [3:0] SEL_HOME_LIMIT   = 4'h7;
  localparam logic [3:0] SEL_HOME_DONE    = 4'h8;
  localparam logic [3:0] SEL_HOME_START   = 4'h9;
  localparam logic [3:0] SEL_INTEG_OFF    = 4'ha;
  localparam logic [3:0] SEL_IN_POSITION  = 4'hb;
  localparam logic [3:0] SEL_JOG_REQ      = 4'hc;
  // ASCII digit base for the one-digit reply
  localparam logic [7:0] DIGIT_ZERO = 8'h30;
  // Register byte offsets
  localparam logic [11:0] OFS_CONFIG  = 12'h000;
  localparam logic [11:0] OFS_FF_GAIN = 12'h004;
  localparam logic [11:0] OFS_INPUTS  = 12'h008;
  localparam logic [11:0] OFS_OUTPUTS = 12'h00c;
  // Config field positions
  localparam int CFG_END_NOTICE = 0;
  localparam int CFG_PHASE      = 1;
  // Gain in units of 0.0001, 10000 = 1.0000
  localparam logic [13:0] FF_GAIN_MAX   = 14'h2710;
  localparam logic [13:0] FF_GAIN_RESET = 14'h2710;
  localparam logic        END_NOTICE_RESET = 1'b0;
  localparam logic        PHASE_RESET      = 1'b0;

  typedef struct packed {
    logic alarm_clear_input;
    logic jog_direction;
    logic emergency_stop_input;
    logic hold_input;
    logic home_limit_input;
    logic home_start_input;
    logic integral_off_input;
    logic jog_request;
  } ism_inputs_t;

  typedef struct packed {
    logic in_operation;
    logic drive_ready_output;
    logic home_defined_output;
    logic home_complete;
    logic in_position_output;
  } ism_outputs_t;
endpackage

// ===== hw/ism_top.sv
// Notes on behaviour
// - Send 0x21 when operation completes, if enabled
// - Defer ready character until line editing ends
// - End notice bit: 0 silent, 1 send
// - Phase order bit: 0 A leads, 1 B
// - Input monitors show filtered, polarity-corrected state
// - Output monitors show state before timer, inversion
// - Alarm clear monitor: 0 off, 1 on
// - In-operation monitor: 0 idle, 1 busy
// - Jog direction monitor: 0 plus, 1 minus
// - Drive ready monitor: 0 alarm, 1 normal
// - Emergency stop monitor: 0 normal, 1 stop
// - Feed-forward gain 0..1.0000, zero disables
// - Home defined monitor: 0 undefined, 1 defined
// - Hold monitor: 0 normal, 1 hold
// - Home limit monitor: 1 near-home detected
// - Home complete: 1 only done and at home
// - Home start monitor: 1 start requested
// - Integral off monitor: 1 integral switched off
// - In-position: 1 completed and target held
// - Jog monitor: 1 accelerate, 0 decelerate
`timescale 1ns/1ns
`default_nettype none
module ism_top (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire ism_pkg::ism_inputs_t  filtered_inputs,
  input  wire ism_pkg::ism_outputs_t function_outputs,
  input  wire logic                  operation_done,
  input  wire logic                  line_editing,
  input  wire logic                  monitor_cmd_valid,
  input  wire logic [3:0]            monitor_cmd_sel,
  output logic                       reply_valid,
  output logic      [7:0]            reply_char,
  input  wire logic                  reply_ready,
  output logic                       feedback_phase_order,
  output logic      [13:0]           feed_forward_gain,
  output logic                       feed_forward_enable
);
  logic                 end_notice_enable_q;
  logic                 phase_q;
  logic [13:0]          gain_q;
  logic                 notice_pend_q;
  logic                 mon_pend_q;
  logic [7:0]           mon_char_q;
  logic [7:0]           reply_q;
  logic                 reply_valid_q;
  logic [31:0]          prdata_q;
  logic                 mon_bit;
  logic                 wr_en;
  logic                 rd_en;
  logic                 addr_ok;
  ism_pkg::ism_inputs_t  in_s;
  ism_pkg::ism_outputs_t out_s;

  // Monitors sample the already-filtered and pre-inversion levels from the core
  assign in_s  = filtered_inputs;
  assign out_s = function_outputs;

  assign addr_ok = (paddr == ism_pkg::OFS_CONFIG) || (paddr == ism_pkg::OFS_FF_GAIN) ||
                   (paddr == ism_pkg::OFS_INPUTS) || (paddr == ism_pkg::OFS_OUTPUTS);
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      end_notice_enable_q <= ism_pkg::END_NOTICE_RESET;
      phase_q             <= ism_pkg::PHASE_RESET;
    end else if (wr_en && paddr == ism_pkg::OFS_CONFIG) begin
      end_notice_enable_q <= pwdata[ism_pkg::CFG_END_NOTICE];
      phase_q             <= pwdata[ism_pkg::CFG_PHASE];
    end
  end

  // Out-of-range gain writes saturate at 1.0000 rather than wrap
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gain_q <= ism_pkg::FF_GAIN_RESET;
    end else if (wr_en && paddr == ism_pkg::OFS_FF_GAIN) begin
      if (pwdata[31:14] != 18'h00000 || pwdata[13:0] > ism_pkg::FF_GAIN_MAX) begin
        gain_q <= ism_pkg::FF_GAIN_MAX;
      end else begin
        gain_q <= pwdata[13:0];
      end
    end
  end

  assign feedback_phase_order = phase_q;
  assign feed_forward_gain    = gain_q;
  assign feed_forward_enable  = (gain_q != 14'h0000);

  // Read data is registered in the setup phase: it is valid throughout the access phase
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == ism_pkg::OFS_CONFIG) begin
        prdata_q <= {30'h00000000, phase_q, end_notice_enable_q};
      end else if (paddr == ism_pkg::OFS_FF_GAIN) begin
        prdata_q <= {18'h00000, gain_q};
      end else if (paddr == ism_pkg::OFS_INPUTS) begin
        prdata_q <= {24'h000000, in_s};
      end else if (paddr == ism_pkg::OFS_OUTPUTS) begin
        prdata_q <= {27'h0000000, out_s};
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  always_comb begin
    case (monitor_cmd_sel)
      ism_pkg::SEL_ALARM_CLEAR:  mon_bit = in_s.alarm_clear_input;
      ism_pkg::SEL_IN_OPERATION: mon_bit = out_s.in_operation;
      ism_pkg::SEL_JOG_DIR:      mon_bit = in_s.jog_direction;
      ism_pkg::SEL_DRIVE_READY:  mon_bit = out_s.drive_ready_output;
      ism_pkg::SEL_EMERG_STOP:   mon_bit = in_s.emergency_stop_input;
      ism_pkg::SEL_HOME_DEFINED: mon_bit = out_s.home_defined_output;
      ism_pkg::SEL_HOLD:         mon_bit = in_s.hold_input;
      ism_pkg::SEL_HOME_LIMIT:   mon_bit = in_s.home_limit_input;
      ism_pkg::SEL_HOME_DONE:    mon_bit = out_s.home_complete;
      ism_pkg::SEL_HOME_START:   mon_bit = in_s.home_start_input;
      ism_pkg::SEL_INTEG_OFF:    mon_bit = in_s.integral_off_input;
      ism_pkg::SEL_IN_POSITION:  mon_bit = out_s.in_position_output;
      ism_pkg::SEL_JOG_REQ:      mon_bit = in_s.jog_request;
      default:                   mon_bit = 1'b0;
    endcase
  end

  // Monitor reply latched at request time; one outstanding request, newer replaces
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mon_pend_q <= 1'b0;
      mon_char_q <= 8'h00;
    end else if (monitor_cmd_valid) begin
      mon_pend_q <= 1'b1;
      mon_char_q <= ism_pkg::DIGIT_ZERO | {7'h00, mon_bit};
    end else if (mon_pend_q && !reply_valid_q) begin
      mon_pend_q <= 1'b0;
    end
  end

  // Completion wins over the clear of the pending notice
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      notice_pend_q <= 1'b0;
    end else if (operation_done && end_notice_enable_q) begin
      notice_pend_q <= 1'b1;
    end else if (!end_notice_enable_q) begin
      notice_pend_q <= 1'b0;
    end else if (!reply_valid_q && !mon_pend_q && !line_editing) begin
      notice_pend_q <= 1'b0;
    end
  end

  // Replies go first; the ready character waits for the editing line to close
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reply_valid_q <= 1'b0;
      reply_q       <= 8'h00;
    end else if (reply_valid_q) begin
      if (reply_ready) begin
        reply_valid_q <= 1'b0;
      end
    end else if (mon_pend_q) begin
      reply_valid_q <= 1'b1;
      reply_q       <= mon_char_q;
    end else if (notice_pend_q && !line_editing) begin
      reply_valid_q <= 1'b1;
      reply_q       <= ism_pkg::READY_CHAR;
    end
  end

  assign reply_valid = reply_valid_q;
  assign reply_char  = reply_q;
endmodule
`default_nettype wire

// ===== test/ism_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ism_chk (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        line_editing,
  input wire logic        monitor_cmd_valid,
  input wire logic        reply_valid,
  input wire logic [7:0]  reply_char,
  input wire logic        reply_ready,
  input wire logic        feedback_phase_order,
  input wire logic [13:0] feed_forward_gain,
  input wire logic        feed_forward_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire logic wr = psel && penable && pwrite;
  // A command still in flight may overwrite the pending monitor character, never a presented reply
  sequence s_stuck;
    !monitor_cmd_valid [*3] ##0 reply_valid && !reply_ready;
  endsequence
  AST_FF_EN: assert property (feed_forward_enable == (feed_forward_gain != 14'h0000))
    else $error("gain enable mismatch");
  AST_FF_MAX: assert property (feed_forward_gain <= 14'h2710)
    else $error("gain above one");
  AST_PHASE: assert property (wr && paddr == 12'h000 |=> feedback_phase_order == $past(pwdata[1]))
    else $error("phase order not written");
  AST_GAIN: assert property (wr && paddr == 12'h004 && pwdata <= 32'h0000_2710
    |=> feed_forward_gain == $past(pwdata[13:0]))
    else $error("gain not written");
  AST_ANSWER: assert property (monitor_cmd_valid && !reply_valid |-> ##[1:3] reply_valid)
    else $error("monitor reply missing");
  AST_HOLD: assert property (s_stuck |=> reply_valid && $stable(reply_char))
    else $error("reply dropped before handshake");
  AST_EDIT: assert property (line_editing && !reply_valid |=> !(reply_valid && reply_char == 8'h21))
    else $error("ready char during editing");
  AST_CHAR: assert property (reply_valid |-> reply_char inside {8'h21, 8'h30, 8'h31})
    else $error("illegal reply char");
endmodule
bind ism_top ism_chk i_ism_chk (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
  .line_editing, .monitor_cmd_valid, .reply_valid, .reply_char, .reply_ready,
  .feedback_phase_order, .feed_forward_gain, .feed_forward_enable);
`default_nettype wire

// ===== test/ism_term.sv
`timescale 1ns/1ns
`default_nettype none
module ism_term (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       stall,
  input  wire logic       reply_valid,
  input  wire logic [7:0] reply_char,
  output logic            reply_ready,
  output logic      [7:0] rx_char,
  output logic      [7:0] rx_cnt
);
  // A slow terminal holds off the handshake while stall is high
  always_ff @(posedge clk_sys) begin
    reply_ready <= !reset && !stall;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_cnt <= 8'h00;
    end else if (reply_valid && reply_ready) begin
      rx_char <= reply_char;
      rx_cnt  <= rx_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== test/ism_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ism_top_tb_top;
  logic                  clk_sys = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0;
  logic                  pwrite = 1'h0, op_done = 1'h0, line_ed = 1'h0, mcv = 1'h0;
  logic                  stall = 1'h0, pready, pslverr, rv, rr, phase, ffen, se;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h0, prdata, rd;
  logic [3:0]            msel = 4'h0;
  logic [7:0]            rc, rx_char, rx_cnt, n;
  logic [13:0]           gain;
  logic [12:0]           v;
  ism_pkg::ism_inputs_t  fin = 8'h00;
  ism_pkg::ism_outputs_t fout = 5'h00;
  int                    mismatches = 0, cmp_count = 0;
  ism_top i_ism_top (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .filtered_inputs(fin), .function_outputs(fout),
    .operation_done(op_done), .line_editing(line_ed), .monitor_cmd_valid(mcv),
    .monitor_cmd_sel(msel), .reply_valid(rv), .reply_char(rc), .reply_ready(rr),
    .feedback_phase_order(phase), .feed_forward_gain(gain), .feed_forward_enable(ffen));
  ism_term i_ism_term (.clk_sys, .reset, .stall, .reply_valid(rv), .reply_char(rc),
    .reply_ready(rr), .rx_char, .rx_cnt);
  initial begin
    forever #50 clk_sys = !clk_sys;
  end
  task automatic final_report;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic tmo(input int i);
    if (i < 40) return;
    mismatches++;
    final_report();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'h1 && i < 40);
    tmo(i);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wait_rx(input logic [7:0] exp);
    int i;
    for (i = 0; i < 40 && rx_cnt === n; i++) @(posedge clk_sys);
    tmo(i);
    chk("reply char", {24'h0, exp}, {24'h0, rx_char});
  endtask
  // Odd codes stall the terminal so the reply must wait
  task automatic mon(input logic [3:0] s, input logic [7:0] exp);
    n = rx_cnt;
    @(posedge clk_sys);
    mcv <= 1'h1;
    msel <= s;
    stall <= s[0];
    @(posedge clk_sys);
    mcv <= 1'h0;
    tick(4);
    stall <= 1'h0;
    wait_rx(exp);
  endtask
  task automatic note(input logic [31:0] cfg);
    apb(1'h1, 12'h000, cfg);
    n = rx_cnt;
    op_done <= 1'h1;
    tick(1);
    op_done <= 1'h0;
    tick(10);
    chk("notice held", {24'h0, n}, {24'h0, rx_cnt});
  endtask
  initial begin
    tick(16);
    reset <= 1'h0;
    apb(1'h0, 12'h000, 32'h0);
    chk("config", 32'h0, rd);
    apb(1'h0, 12'h004, 32'h0);
    chk("gain", 32'h0000_2710, rd);
    apb(1'h1, 12'h004, 32'h0);
    tick(1);
    chk("ff enable", 32'h0, {31'h0, ffen});
    apb(1'h1, 12'h004, 32'h0000_3fff);
    apb(1'h0, 12'h004, 32'h0);
    chk("gain sat", 32'h0000_2710, rd);
    apb(1'h1, 12'h000, 32'h0000_0002);
    tick(1);
    chk("phase", 32'h1, {31'h0, phase});
    apb(1'h0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, se});
    for (int p = 0; p < 2; p++) begin
      fin <= p ? 8'h5a : 8'ha5;
      fout <= p ? 5'h09 : 5'h16;
      apb(1'h0, 12'h008, 32'h0);
      chk("inputs", {24'h0, fin}, rd);
      apb(1'h0, 12'h00c, 32'h0);
      chk("outputs", {27'h0, fout}, rd);
      v = {fin[0], fout[0], fin[1], fin[2], fout[1], fin[3], fin[4], fout[2], fin[5],
        fout[3], fin[6], fout[4], fin[7]};
      for (int s = 0; s < 13; s++)
        mon(s[3:0], {7'h18, v[s]});
    end
    mon(4'hd, 8'h30);
    line_ed <= 1'h1;
    note(32'h1);
    line_ed <= 1'h0;
    wait_rx(8'h21);
    note(32'h0);
    final_report();
  end
endmodule
`default_nettype wire
